// *** design/pcsf_pkg.sv ***
// Package of offsets, field positions, encodings and reset values for the charger status flags.
`default_nettype none

package pcsf_pkg;

    // Register offsets on the register port.
    localparam logic [7:0] PCSF_OFF_FAULT   = 8'h10;
    localparam logic [7:0] PCSF_OFF_EVENT   = 8'h11;
    localparam logic [7:0] PCSF_OFF_MATCH1  = 8'h12;
    localparam logic [7:0] PCSF_OFF_MATCH2  = 8'h13;

    // Fault flag register fields.
    localparam int PCSF_FLT_ERR  = 7;
    localparam int PCSF_FLT_OVL  = 0;

    // Event status register fields.
    localparam int PCSF_EVT_QUOTA  = 7;
    localparam int PCSF_EVT_CCREG  = 4;
    localparam int PCSF_EVT_THERM  = 3;
    localparam int PCSF_EVT_LOWCUR = 2;
    localparam int PCSF_EVT_UNPLUG = 1;
    localparam int PCSF_EVT_PLUG   = 0;

    // Primary charger match register fields.
    localparam int PCSF_M1_NOHS = 7;
    localparam int PCSF_M1_UVLO = 4;
    localparam int PCSF_M1_USER_PROFILE_HANDSHAKE = 3;
    localparam int PCSF_M1_DCP  = 2;
    localparam int PCSF_M1_CDP  = 1;
    localparam int PCSF_M1_PT   = 0;

    // Legacy match register: profile n sits at bit n-1, profiles 3 to 7.
    localparam int PCSF_LEG_LO = 2;
    localparam int PCSF_LEG_HI = 6;
    localparam int PCSF_LEG_N  = 5;

    // Quota action encodings.
    localparam logic [1:0] PCSF_QA_REPORT      = 2'h0;
    localparam logic [1:0] PCSF_QA_REPORT_DISC = 2'h1;
    localparam logic [1:0] PCSF_QA_DISC_SLEEP  = 2'h2;
    localparam logic [1:0] PCSF_QA_IGNORE      = 2'h3;

    // Current limiting mode encodings.
    localparam logic PCSF_LIMIT_TRIP  = 1'b0;
    localparam logic PCSF_LIMIT_CONST = 1'b1;

    // Reset values.
    localparam logic [7:0] PCSF_RST_REG  = 8'h00;
    localparam logic       PCSF_RST_PIN_N = 1'b1;

    typedef struct packed {
        logic       err;
        logic       ovl;
        logic [7:0] evt;
        logic [7:0] match1;
        logic [7:0] match2;
        logic       pt_armed;
        logic       m1_prev;
        logic       attach_n;
        logic       alert_n;
        logic       hs_switch;
        logic       limit_mode;
        logic       hold_off;
        logic [7:0] rdata;
    } pcsf_state_t;

endpackage

`default_nettype wire

// *** design/pcsf_flags.sv ***
// Status flag bank of the port power controller: fault, event and charger match registers.
`default_nettype none

module pcsf_flags
    import pcsf_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Register port from the serial interface engine.
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // Analog comparators and fault sources.
    input  wire logic       ibus_over_limit,
    input  wire logic       ibus_over_r2min,
    input  wire logic [5:0] other_fault_bits,
    input  wire logic       other_fault_event,
    input  wire logic       auto_recovery_en,
    input  wire logic       port_power_enable,
    input  wire logic       supply_below_uvlo,
    input  wire logic       temp_over_reg,
    input  wire logic       near_idle_current,
    // Charge rationing.
    input  wire logic       quota_reached,
    input  wire logic [1:0] quota_action,
    input  wire logic       quota_clear,
    input  wire logic       quota_enable,
    // Alert configuration.
    input  wire logic       alert_mask,
    input  wire logic       alert_link,
    // Attach and removal detection.
    input  wire logic       plug_in_event,
    input  wire logic       unplug_event,
    // Mode selection and emulation sequencer.
    input  wire logic       active_mode_change,
    input  wire logic       passthrough_mode,
    input  wire logic       mode_select_first,
    input  wire logic       dedicated_emulation_cycle,
    input  wire logic       profile_applied,
    input  wire logic       no_handshake_event,
    input  wire logic       user_profile_handshake,
    input  wire logic       dcp_accept,
    input  wire logic       cdp_handshake,
    input  wire logic [4:0] legacy_handshake,
    input  wire logic       dedicated_cycle_switch_setting,
    input  wire logic       custom_switch_setting,
    input  wire logic       custom_limit_mode,
    // Outputs.
    output logic            error_state,
    output logic            alert_pin_n_o,
    output logic            alert_pin_n_oe,
    output logic            attach_detect_pin_n_o,
    output logic            attach_detect_pin_n_oe,
    output logic            port_switch_hold_off,
    output logic            hs_switch_closed,
    output logic            limit_mode
);

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    function automatic logic quota_notifies(input logic [1:0] act);
        quota_notifies = (act == PCSF_QA_REPORT) || (act == PCSF_QA_REPORT_DISC);
    endfunction

    pcsf_state_t st_ff;
    pcsf_state_t nxt_st;

    logic ov_cond;
    logic rd_fault;
    logic rd_event;
    logic err_wr_zero;
    logic err_may_clear;
    logic err_clear;
    logic prof_clear;
    logic m1_toggle;
    logic pt_set;
    logic nohs_set;
    logic alert_req;
    logic [4:0] leg_set;

    always_comb
    begin
        nxt_st        = st_ff;
        ov_cond       = ibus_over_limit && ibus_over_r2min;
        rd_fault      = reg_rd && addr_hit(reg_addr, PCSF_OFF_FAULT);
        rd_event      = reg_rd && addr_hit(reg_addr, PCSF_OFF_EVENT);
        err_wr_zero   = reg_wr && addr_hit(reg_addr, PCSF_OFF_FAULT) && !reg_wdata[PCSF_FLT_ERR];
        err_may_clear = !ov_cond && !other_fault_event && (other_fault_bits == 6'h00);
        err_clear     = 1'b0;
        prof_clear    = !port_power_enable || active_mode_change || unplug_event;
        m1_toggle     = (mode_select_first != st_ff.m1_prev);
        leg_set       = legacy_handshake & {PCSF_LEG_N{dedicated_emulation_cycle}};

        // A new fault always wins over any clearing path in the same cycle.
        if (ov_cond || other_fault_event)
        begin
            nxt_st.err = 1'b1;
        end
        else if (!port_power_enable)
        begin
            nxt_st.err = 1'b0;
            err_clear  = st_ff.err;
        end
        else if ((err_wr_zero || auto_recovery_en) && err_may_clear)
        begin
            nxt_st.err = 1'b0;
            err_clear  = st_ff.err;
        end

        if (ov_cond)
        begin
            nxt_st.ovl = 1'b1;
        end
        else if (rd_fault || err_clear)
        begin
            nxt_st.ovl = 1'b0;
        end

        // Clear-on-read bits, except CCREG which follows ibus_over_limit live: the read returns the old value, a same-cycle set survives.
        nxt_st.evt[PCSF_EVT_QUOTA] = quota_reached ||
            (st_ff.evt[PCSF_EVT_QUOTA] && !rd_event && !quota_clear && quota_enable);
        nxt_st.evt[6:5]             = 2'h0;
        nxt_st.evt[PCSF_EVT_CCREG]  = ibus_over_limit;
        nxt_st.evt[PCSF_EVT_THERM]  = temp_over_reg ||
            (st_ff.evt[PCSF_EVT_THERM] && !rd_event);
        nxt_st.evt[PCSF_EVT_LOWCUR] = near_idle_current ||
            (st_ff.evt[PCSF_EVT_LOWCUR] && !rd_event);
        nxt_st.evt[PCSF_EVT_UNPLUG] = unplug_event ||
            (st_ff.evt[PCSF_EVT_UNPLUG] && !rd_event);
        nxt_st.evt[PCSF_EVT_PLUG]   = plug_in_event ||
            (st_ff.evt[PCSF_EVT_PLUG] && !rd_event);

        // Attach wins over a removal reported in the same cycle.
        if (plug_in_event)
        begin
            nxt_st.attach_n = 1'b0;
        end
        else if (unplug_event)
        begin
            nxt_st.attach_n = 1'b1;
        end

        // Pass-through indication is armed by reset, a mode change or a first-select toggle only.
        nxt_st.m1_prev = mode_select_first;
        if (active_mode_change || m1_toggle)
        begin
            nxt_st.pt_armed = 1'b1;
        end
        else if (unplug_event)
        begin
            nxt_st.pt_armed = 1'b0;
        end
        pt_set = passthrough_mode && port_power_enable && st_ff.pt_armed && !unplug_event;

        nxt_st.match1[6:5] = 2'h0;
        nxt_st.match1[PCSF_M1_UVLO] = supply_below_uvlo;
        nxt_st.match1[PCSF_M1_USER_PROFILE_HANDSHAKE] = (user_profile_handshake && dedicated_emulation_cycle) ||
            (st_ff.match1[PCSF_M1_USER_PROFILE_HANDSHAKE] && !prof_clear);
        nxt_st.match1[PCSF_M1_DCP]  = dcp_accept ||
            (st_ff.match1[PCSF_M1_DCP] && !prof_clear);
        nxt_st.match1[PCSF_M1_CDP]  = cdp_handshake ||
            (st_ff.match1[PCSF_M1_CDP] && !prof_clear);
        nxt_st.match1[PCSF_M1_PT]   = pt_set ||
            (st_ff.match1[PCSF_M1_PT] && !prof_clear && passthrough_mode);

        nxt_st.match2[7] = 1'b0;
        nxt_st.match2[1:0] = 2'h0;
        nxt_st.match2[PCSF_LEG_HI:PCSF_LEG_LO] = leg_set |
            (st_ff.match2[PCSF_LEG_HI:PCSF_LEG_LO] & ~{PCSF_LEG_N{prof_clear}});

        // The no-handshake flag yields to any other indicator so the two never coexist.
        nohs_set = no_handshake_event && dedicated_emulation_cycle;
        if (nohs_set)
        begin
            nxt_st.match1[PCSF_M1_NOHS] = 1'b1;
        end
        else if (profile_applied)
        begin
            nxt_st.match1[PCSF_M1_NOHS] = 1'b0;
        end
        if ((nxt_st.match1[4:0] != 5'h00) || (nxt_st.match2 != PCSF_RST_REG))
        begin
            nxt_st.match1[PCSF_M1_NOHS] = 1'b0;
        end

        // Switch and limiting follow the strongest accepted profile.
        if (nxt_st.match1[PCSF_M1_CDP] || nxt_st.match1[PCSF_M1_PT])
        begin
            nxt_st.hs_switch  = 1'b1;
            nxt_st.limit_mode = PCSF_LIMIT_TRIP;
        end
        else if (nxt_st.match1[PCSF_M1_DCP])
        begin
            nxt_st.hs_switch  = dedicated_cycle_switch_setting;
            nxt_st.limit_mode = PCSF_LIMIT_CONST;
        end
        else if (nxt_st.match1[PCSF_M1_USER_PROFILE_HANDSHAKE])
        begin
            nxt_st.hs_switch  = custom_switch_setting;
            nxt_st.limit_mode = custom_limit_mode;
        end
        else if (nxt_st.match2[PCSF_LEG_HI:PCSF_LEG_LO] != 5'h00)
        begin
            nxt_st.hs_switch  = dedicated_cycle_switch_setting;
            nxt_st.limit_mode = custom_limit_mode;
        end
        else
        begin
            nxt_st.hs_switch  = 1'b0;
            nxt_st.limit_mode = PCSF_LIMIT_TRIP;
        end
        nxt_st.hold_off = supply_below_uvlo;

        // Alert looks at flags, not at the error state, and never at match or attach bits.
        alert_req = !alert_mask && (
            st_ff.ovl || (other_fault_bits != 6'h00) ||
            (st_ff.evt[PCSF_EVT_QUOTA] && quota_notifies(quota_action)) ||
            (alert_link && (st_ff.evt[PCSF_EVT_THERM] || st_ff.evt[PCSF_EVT_LOWCUR])));
        nxt_st.alert_n = !alert_req;

        nxt_st.rdata = PCSF_RST_REG;
        if (reg_rd)
        begin
            unique case (reg_addr)
                PCSF_OFF_FAULT:
                begin
                    nxt_st.rdata = {st_ff.err, other_fault_bits, st_ff.ovl};
                end
                PCSF_OFF_EVENT:  nxt_st.rdata = st_ff.evt;
                PCSF_OFF_MATCH1: nxt_st.rdata = st_ff.match1;
                PCSF_OFF_MATCH2: nxt_st.rdata = st_ff.match2;
                default:         nxt_st.rdata = PCSF_RST_REG;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff            <= '0;
            st_ff.pt_armed   <= 1'b1;
            st_ff.attach_n   <= PCSF_RST_PIN_N;
            st_ff.alert_n    <= PCSF_RST_PIN_N;
            st_ff.limit_mode <= PCSF_LIMIT_TRIP;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata              = st_ff.rdata;
    assign error_state            = st_ff.err;
    assign alert_pin_n_o          = 1'b0;
    assign alert_pin_n_oe         = !st_ff.alert_n;
    assign attach_detect_pin_n_o  = 1'b0;
    assign attach_detect_pin_n_oe = !st_ff.attach_n;
    assign port_switch_hold_off   = st_ff.hold_off;
    assign hs_switch_closed       = st_ff.hs_switch;
    assign limit_mode             = st_ff.limit_mode;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ov_seen;
        ibus_over_limit && ibus_over_r2min && !alert_mask ##1 !alert_mask;
    endsequence

    sequence s_replug_no_rearm;
        unplug_event && !active_mode_change && !m1_toggle ##1 !active_mode_change && !m1_toggle;
    endsequence

    a_ov_flag_err: assert property (ov_cond |=> st_ff.ovl && st_ff.err)
        else $error("overcurrent did not set flag and error state");
    a_ov_alert: assert property (s_ov_seen |=> alert_pin_n_oe)
        else $error("overcurrent did not assert alert");
    a_ov_read_keep: assert property (rd_fault && ov_cond |=> st_ff.ovl)
        else $error("overcurrent flag cleared while condition present");
    a_err_power_off: assert property
        (!port_power_enable && !ov_cond && !other_fault_event |=> !error_state)
        else $error("error state held with power enable off");
    a_err_recheck: assert property
        (err_wr_zero && error_state && port_power_enable && !err_may_clear |=> error_state)
        else $error("error state left with fault present");
    a_quota_clear: assert property
        (quota_clear && !quota_reached |=> !st_ff.evt[PCSF_EVT_QUOTA])
        else $error("quota flag survived quota clear");
    a_cc_live: assert property (st_ff.evt[PCSF_EVT_CCREG] == $past(ibus_over_limit))
        else $error("region 2 bit does not track current");
    a_link_alert: assert property
        (st_ff.evt[PCSF_EVT_THERM] && alert_link && !alert_mask |=> alert_pin_n_oe)
        else $error("thermal flag with link did not raise alert");
    a_attach_pin: assert property (plug_in_event |=> attach_detect_pin_n_oe)
        else $error("attach did not assert attach pin");
    a_removal_pin: assert property
        (unplug_event && !plug_in_event |=> !attach_detect_pin_n_oe)
        else $error("removal did not release attach pin");
    a_read_clears: assert property
        (rd_event && !plug_in_event |=> !st_ff.evt[PCSF_EVT_PLUG])
        else $error("attach flag not cleared by read");
    a_read_set_wins: assert property
        (rd_event && plug_in_event |=> st_ff.evt[PCSF_EVT_PLUG])
        else $error("attach event lost on clearing read");
    a_prof_clear: assert property
        (prof_clear && legacy_handshake == 5'h00 |=> st_ff.match2 == PCSF_RST_REG)
        else $error("legacy indicators survived clear event");
    a_nohs_alone: assert property
        (st_ff.match1[PCSF_M1_NOHS] |-> st_ff.match1[4:0] == 5'h00 &&
         st_ff.match2 == PCSF_RST_REG)
        else $error("no-handshake flag set with other indicator");
    a_uvlo_hold: assert property
        (supply_below_uvlo |=> st_ff.match1[PCSF_M1_UVLO] && port_switch_hold_off)
        else $error("undervoltage not indicated or switch not held");
    a_cdp_switch: assert property
        (cdp_handshake && port_power_enable |=> hs_switch_closed &&
         limit_mode == PCSF_LIMIT_TRIP)
        else $error("CDP did not close switch with trip limiting");
    a_pt_no_rearm: assert property
        (s_replug_no_rearm |=> !st_ff.match1[PCSF_M1_PT])
        else $error("pass-through flag set again without re-arm");

    // A flag stuck high hides from reads alone, so the release side is watched as well.
    a_quota_notify: assert property
        (st_ff.evt[PCSF_EVT_QUOTA] && !alert_mask && quota_notifies(quota_action) |=>
         alert_pin_n_oe)
        else $error("quota flag with notify action did not raise alert");
    a_thermal_set: assert property (temp_over_reg |=> st_ff.evt[PCSF_EVT_THERM])
        else $error("thermal event did not set its flag");
    a_ov_err_clear: assert property (err_clear && !ov_cond |=> !st_ff.ovl)
        else $error("overcurrent flag survived error clear");
    a_nohs_outside: assert property
        (!dedicated_emulation_cycle && !st_ff.match1[PCSF_M1_NOHS] |=>
         !st_ff.match1[PCSF_M1_NOHS])
        else $error("no-handshake flag set outside dedicated cycle");
    a_legacy_dce: assert property
        (!dedicated_emulation_cycle && st_ff.match2 == PCSF_RST_REG |=>
         st_ff.match2 == PCSF_RST_REG)
        else $error("legacy indicator set outside dedicated cycle");
    a_uvlo_release: assert property
        (!supply_below_uvlo |=> !st_ff.match1[PCSF_M1_UVLO] && !port_switch_hold_off)
        else $error("undervoltage indication held after supply recovered");

endmodule

`default_nettype wire

// *** tb/pcsf_host_model.sv ***
// Host controller model that reads and writes the status registers over the register port.
`default_nettype none

module pcsf_host_model
(
    input  wire logic       ref_clk,
    output logic [7:0]      reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // Entered at a falling edge; the strobe spans one rising edge, then one idle edge follows.
    // The idle edge keeps a back-to-back call from raising the strobe in the step that dropped it.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        // A released bus must not keep showing the old address.
        reg_addr = ~a;
        d = reg_rdata;
        @(negedge ref_clk);
    endtask

    // Writing 0 to the error flag is how the host asks to leave the Error state.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        @(negedge ref_clk);
    endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the charger status flag bank.
`default_nettype none

module tb_top
    import pcsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = '0, resetn = '0, ibus_over_limit = '0, ibus_over_r2min = '0;
    logic other_fault_event = '0, auto_recovery_en = '0, port_power_enable = '0;
    logic supply_below_uvlo = '0, temp_over_reg = '0, near_idle_current = '0;
    logic quota_reached = '0, quota_clear = '0, quota_enable = '0, alert_mask = '0;
    logic alert_link = '0, plug_in_event = '0, unplug_event = '0, active_mode_change = '0;
    logic passthrough_mode = '0, mode_select_first = '0, dedicated_emulation_cycle = '0;
    logic profile_applied = '0, no_handshake_event = '0, user_profile_handshake = '0;
    logic dcp_accept = '0, cdp_handshake = '0, dedicated_cycle_switch_setting = '0;
    logic custom_switch_setting = '0, custom_limit_mode = '0, sw = '0, lim = '0;
    logic [1:0] quota_action = '0;
    logic [4:0] legacy_handshake = '0;
    logic [5:0] other_fault_bits = '0;
    logic       reg_rd, reg_wr, error_state, alert_pin_n_o, alert_pin_n_oe, limit_mode;
    logic       attach_detect_pin_n_o, attach_detect_pin_n_oe, port_switch_hold_off;
    logic       hs_switch_closed;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int         n_mismatch = 0;
    int         checks = 0;
    int         seed;

    pcsf_flags DUT (.ref_clk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
        .ibus_over_limit, .ibus_over_r2min, .other_fault_bits, .other_fault_event,
        .auto_recovery_en, .port_power_enable, .supply_below_uvlo, .temp_over_reg,
        .near_idle_current, .quota_reached, .quota_action, .quota_clear, .quota_enable,
        .alert_mask, .alert_link, .plug_in_event, .unplug_event, .active_mode_change,
        .passthrough_mode, .mode_select_first, .dedicated_emulation_cycle, .profile_applied,
        .no_handshake_event, .user_profile_handshake, .dcp_accept, .cdp_handshake,
        .legacy_handshake, .dedicated_cycle_switch_setting, .custom_switch_setting,
        .custom_limit_mode, .error_state, .alert_pin_n_o, .alert_pin_n_oe,
        .attach_detect_pin_n_o, .attach_detect_pin_n_oe, .port_switch_hold_off,
        .hs_switch_closed, .limit_mode);

    pcsf_host_model host (.ref_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata);

    always #10 ref_clk = ~ref_clk;

    function automatic logic [7:0] leg_bit(input int k);
        return 8'h01 << (k + PCSF_LEG_LO);
    endfunction

    function automatic logic quota_alerts(input logic [1:0] a);
        return (a == PCSF_QA_REPORT) || (a == PCSF_QA_REPORT_DISC);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        check(d, exp);
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        stop_test;
    end

    initial
    begin
        seed = $urandom(32'h7716);
        port_power_enable = 1'b1;
        quota_enable = 1'b1;
        tick(2);
        resetn = 1'b1;
        for (int a = 16; a <= 20; a++)
            rdchk(8'(a), 8'h00);
        check({alert_pin_n_oe, attach_detect_pin_n_oe}, 8'h00);
        check({alert_pin_n_o, attach_detect_pin_n_o}, 8'h00);
        $display("reset test done");
        ibus_over_limit = 1'b1;
        ibus_over_r2min = 1'b1;
        tick(2);
        check(error_state, 8'h01);
        check(alert_pin_n_oe, 8'h01);
        rdchk(PCSF_OFF_FAULT, 8'h81);
        rdchk(PCSF_OFF_FAULT, 8'h81);
        rdchk(PCSF_OFF_EVENT, 8'h10);
        ibus_over_r2min = 1'b0;
        tick(1);
        rdchk(PCSF_OFF_FAULT, 8'h81);
        rdchk(PCSF_OFF_FAULT, 8'h80);
        check({alert_pin_n_oe, error_state}, 8'h01);
        ibus_over_limit = 1'b0;
        tick(1);
        rdchk(PCSF_OFF_EVENT, 8'h00);
        host.wr(PCSF_OFF_FAULT, 8'h00);
        tick(1);
        check(error_state, 8'h00);
        ibus_over_limit = 1'b1;
        ibus_over_r2min = 1'b1;
        tick(2);
        ibus_over_limit = 1'b0;
        ibus_over_r2min = 1'b0;
        tick(1);
        check(error_state, 8'h01);
        port_power_enable = 1'b0;
        tick(2);
        port_power_enable = 1'b1;
        check(error_state, 8'h00);
        rdchk(PCSF_OFF_FAULT, 8'h00);
        other_fault_bits = 6'($urandom) | 6'h01;
        other_fault_event = 1'b1;
        tick(1);
        other_fault_event = 1'b0;
        host.wr(PCSF_OFF_FAULT, 8'h00);
        check(error_state, 8'h01);
        check(alert_pin_n_oe, 8'h01);
        rdchk(PCSF_OFF_FAULT, {1'b1, other_fault_bits, 1'b0});
        alert_mask = 1'b1;
        tick(2);
        check({alert_pin_n_oe, error_state}, 8'h01);
        other_fault_bits = '0;
        alert_mask = 1'b0;
        auto_recovery_en = 1'b1;
        tick(1);
        auto_recovery_en = 1'b0;
        check(error_state, 8'h00);
        $display("fault test done");
        for (int l = 0; l < 2; l++)
        begin
            alert_link = l[0];
            temp_over_reg = 1'b1;
            near_idle_current = 1'b1;
            tick(1);
            temp_over_reg = 1'b0;
            near_idle_current = 1'b0;
            tick(1);
            check(alert_pin_n_oe, 8'(l));
            rdchk(PCSF_OFF_EVENT, 8'h0c);
            rdchk(PCSF_OFF_EVENT, 8'h00);
        end
        pulse(plug_in_event);
        check(attach_detect_pin_n_oe, 8'h01);
        tick(1);
        check(alert_pin_n_oe, 8'h00);
        rdchk(PCSF_OFF_EVENT, 8'h01);
        fork
            host.rd(PCSF_OFF_EVENT, d);
            pulse(plug_in_event);
        join
        check(d, 8'h00);
        rdchk(PCSF_OFF_EVENT, 8'h01);
        pulse(unplug_event);
        check(attach_detect_pin_n_oe, 8'h00);
        rdchk(PCSF_OFF_EVENT, 8'h02);
        check(alert_pin_n_oe, 8'h00);
        $display("event test done");
        for (int a = 0; a < 4; a++)
        begin
            quota_action = 2'(a);
            pulse(quota_reached);
            tick(1);
            check(alert_pin_n_oe, quota_alerts(2'(a)));
            if (a == 3)
                rdchk(PCSF_OFF_EVENT, 8'h80);
            else if (a[0])
                pulse(quota_clear);
            else
                quota_enable = 1'b0;
            tick(2);
            rdchk(PCSF_OFF_EVENT, 8'h00);
            quota_enable = 1'b1;
        end
        $display("quota test done");
        dedicated_emulation_cycle = 1'b1;
        sw = 1'($urandom);
        lim = 1'($urandom);
        dedicated_cycle_switch_setting = sw;
        custom_switch_setting = !sw;
        custom_limit_mode = lim;
        for (int k = 0; k < PCSF_LEG_N; k++)
        begin
            legacy_handshake = 5'h01 << k;
            tick(1);
            legacy_handshake = '0;
            rdchk(PCSF_OFF_MATCH2, leg_bit(k));
            check({hs_switch_closed, limit_mode}, {sw, lim});
            check({alert_pin_n_oe, attach_detect_pin_n_oe}, 8'h00);
            pulse(active_mode_change);
            rdchk(PCSF_OFF_MATCH2, 8'h00);
        end
        pulse(cdp_handshake);
        rdchk(PCSF_OFF_MATCH1, 8'h02);
        check({hs_switch_closed, limit_mode}, {1'b1, PCSF_LIMIT_TRIP});
        pulse(unplug_event);
        rdchk(PCSF_OFF_MATCH1, 8'h00);
        pulse(dcp_accept);
        rdchk(PCSF_OFF_MATCH1, 8'h04);
        check({hs_switch_closed, limit_mode}, {sw, PCSF_LIMIT_CONST});
        port_power_enable = 1'b0;
        tick(1);
        port_power_enable = 1'b1;
        rdchk(PCSF_OFF_MATCH1, 8'h00);
        pulse(user_profile_handshake);
        pulse(no_handshake_event);
        rdchk(PCSF_OFF_MATCH1, 8'h08);
        check({hs_switch_closed, limit_mode}, {!sw, lim});
        pulse(active_mode_change);
        pulse(no_handshake_event);
        rdchk(PCSF_OFF_MATCH1, 8'h80);
        pulse(profile_applied);
        rdchk(PCSF_OFF_MATCH1, 8'h00);
        passthrough_mode = 1'b1;
        tick(2);
        rdchk(PCSF_OFF_MATCH1, 8'h01);
        check({hs_switch_closed, limit_mode}, {1'b1, PCSF_LIMIT_TRIP});
        pulse(unplug_event);
        pulse(plug_in_event);
        rdchk(PCSF_OFF_MATCH1, 8'h00);
        mode_select_first = 1'b1;
        tick(2);
        rdchk(PCSF_OFF_MATCH1, 8'h01);
        supply_below_uvlo = 1'b1;
        tick(2);
        check(port_switch_hold_off, 8'h01);
        rdchk(PCSF_OFF_MATCH1, 8'h11);
        supply_below_uvlo = 1'b0;
        tick(2);
        rdchk(PCSF_OFF_MATCH1, 8'h01);
        $display("profile test done");
        stop_test;
    end
endmodule

`default_nettype wire
